// *** vps_regs.v ***
// voltage protection limits, ceilings, pending level and status register groups
`timescale 1ns/1ps
`include "vps_defines.vh"
//
// Summary of operation
// - negative protection limit stored by command, range minimum up to rated plus 1%.
// - positive protection limit stored by command, range minimum up to rated plus 1%; above it posts error -222.
// - combined ceiling sets both ceilings; persists only after persist command.
// - separate negative ceiling, up to rated plus 1%, persisted by update.
// - separate positive ceiling, up to rated plus 1%, persisted by update.
// - combined ceiling query answers positive ceiling, then negative ceiling.
// - pending trigger level; above model maximum posts error -222.
// - pending level above software cap stores the cap instead.
// - pending level query returns value next trigger would program.
// - operation condition is live, unlatched; one means active.
// - operation bits 14,12,11,10,9,8,6,5; others unused.
// - operation summary is OR of enabled operation event bits.
// - operation event latches every event; read returns then clears.
// - status preset loads operation enable 8193, questionable enable 255.
// - questionable event latches only bits 13 and 12; bits 0,1 never.
// - questionable event read-only; read returns latched value then clears.
// - questionable bits 14,13,12,6,3,1,0; others unused.
// - operation enable read returns current mask bits.
// - questionable summary is OR of enabled questionable event bits.
// - common limit write lowers only the limit exceeding its ceiling.
// - lesser mode applies smaller of external and command limits.
module vps_regs #(
  parameter [15:0] RATED_V = 16'h8ca0,
  parameter [15:0] MIN_BOX = 16'h0064,
  parameter [15:0] MODEL_MAX = 16'h8ca0
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  // host command port
  input wire cmd_valid,
  input wire [`VPS_CW-1:0] cmd_code,
  input wire [`VPS_VW-1:0] cmd_data,
  output reg cmd_ready_r,
  // host answer port
  output reg rsp_valid_r,
  output reg rsp_err_r,
  output reg [`VPS_VW-1:0] rsp_data_r,
  // operation condition pins
  input wire list_active_flag,
  input wire list_done_flag,
  input wire sample_done_flag,
  input wire const_current_flag,
  input wire transient_done_flag,
  input wire const_voltage_flag,
  input wire transient_primed_flag,
  input wire awaiting_trigger_flag,
  // questionable condition pins
  input wire absorbing_energy_flag,
  input wire current_fault_flag,
  input wire voltage_fault_flag,
  input wire follower_fault_flag,
  input wire thermal_fault_flag,
  input wire current_mode_fault_flag,
  input wire voltage_mode_fault_flag,
  // limits from neighbouring logic on this clock
  input wire [`VPS_VW-1:0] software_voltage_cap,
  input wire [`VPS_VW-1:0] ext_pos_limit,
  input wire [`VPS_VW-1:0] ext_neg_limit,
  // nonvolatile store of ceilings
  input wire [`VPS_VW-1:0] nv_pos_ceil,
  input wire [`VPS_VW-1:0] nv_neg_ceil,
  output reg nv_wr_r,
  output reg [`VPS_VW-1:0] nv_pos_wdata_r,
  output reg [`VPS_VW-1:0] nv_neg_wdata_r,
  // results
  output reg [`VPS_VW-1:0] pending_level_r,
  output reg [`VPS_VW-1:0] eff_pos_limit_r,
  output reg [`VPS_VW-1:0] eff_neg_limit_r,
  output reg oper_summary_r,
  output reg ques_summary_r
);

  // highest limit or ceiling: rated plus one percent
  localparam [15:0] PROT_MAX = RATED_V + RATED_V / 16'h0064;

  ////////////////////////////////////////////////////////////////////////
  // condition inputs

  wire [15:0] oper_raw;
  wire [15:0] ques_raw;
  wire [15:0] oper_sync;
  wire [15:0] ques_sync;
  wire [15:0] oper_cond;
  wire [15:0] ques_cond;
  wire [15:0] oper_evt;
  wire [15:0] ques_evt;

  // pack pins into their bit slots, unused slots zero
  assign oper_raw = {1'b0, list_active_flag, 1'b0, list_done_flag, sample_done_flag,
    const_current_flag, transient_done_flag, const_voltage_flag, 1'b0,
    transient_primed_flag, awaiting_trigger_flag, 5'h00};
  assign ques_raw = {1'b0, absorbing_energy_flag, current_fault_flag, voltage_fault_flag,
    5'h00, follower_fault_flag, 2'h0, thermal_fault_flag, 1'b0,
    current_mode_fault_flag, voltage_mode_fault_flag};

  vps_sync #(
    .W(32)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({oper_raw, ques_raw}),
    .sync_out({oper_sync, ques_sync})
  );

  // live, unlatched conditions with unused bits forced zero
  assign oper_cond = oper_sync & `VPS_OPER_USED;
  assign ques_cond = ques_sync & `VPS_QUES_USED;

  ////////////////////////////////////////////////////////////////////////
  // command decode

  wire take;
  wire rd_oper_evt;
  wire rd_ques_evt;
  wire [`VPS_VW-1:0] d;
  wire d_ok;

  assign take = cmd_valid & cmd_ready_r;
  assign d = cmd_data;
  assign d_ok = (d >= MIN_BOX) && (d <= PROT_MAX);
  assign rd_oper_evt = take && (cmd_code == `VPS_C_OPER_EVT_RD);
  assign rd_ques_evt = take && (cmd_code == `VPS_C_QUES_EVT_RD);

  vps_evt #(
    .LATCH(`VPS_OPER_LATCH)
  ) u_oper_evt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .cond(oper_cond),
    .rd_clr(rd_oper_evt),
    .evt_r(oper_evt)
  );

  vps_evt #(
    .LATCH(`VPS_QUES_LATCH)
  ) u_ques_evt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .cond(ques_cond),
    .rd_clr(rd_ques_evt),
    .evt_r(ques_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // stored values

  reg [`VPS_VW-1:0] neg_prot_r;
  reg [`VPS_VW-1:0] pos_prot_r;
  reg [`VPS_VW-1:0] neg_ceil_r;
  reg [`VPS_VW-1:0] pos_ceil_r;
  reg [1:0] prot_mode_r;
  reg [15:0] oper_en_r;
  reg [15:0] ques_en_r;
  reg boot_r;
  reg [`VPS_VW-1:0] second_r;
  reg [`VPS_VW-1:0] rsp_nxt;
  reg rsp_go;
  reg rsp_two;
  reg [`VPS_VW-1:0] second_nxt;

  // answer word for queries; two-word queries park the second word
  always @* begin
    rsp_go = 1'b1;
    rsp_two = 1'b0;
    second_nxt = 16'h0000;
    case (cmd_code)
      `VPS_C_PROT_NEG_RD: rsp_nxt = neg_prot_r;
      `VPS_C_PROT_POS_RD: rsp_nxt = pos_prot_r;
      `VPS_C_PROT_BOTH_RD: begin
        rsp_nxt = pos_prot_r;
        rsp_two = 1'b1;
        second_nxt = neg_prot_r;
      end
      `VPS_C_CEIL_BOTH_RD: begin
        rsp_nxt = pos_ceil_r;
        rsp_two = 1'b1;
        second_nxt = neg_ceil_r;
      end
      `VPS_C_CEIL_NEG_RD: rsp_nxt = neg_ceil_r;
      `VPS_C_CEIL_POS_RD: rsp_nxt = pos_ceil_r;
      `VPS_C_TRIG_RD: rsp_nxt = pending_level_r;
      `VPS_C_PMODE_RD: rsp_nxt = {14'h0000, prot_mode_r};
      `VPS_C_OPER_COND_RD: rsp_nxt = oper_cond;
      `VPS_C_OPER_EN_RD: rsp_nxt = oper_en_r;
      `VPS_C_OPER_EVT_RD: rsp_nxt = oper_evt;
      `VPS_C_QUES_EVT_RD: rsp_nxt = ques_evt;
      `VPS_C_QUES_COND_RD: rsp_nxt = ques_cond;
      `VPS_C_QUES_EN_RD: rsp_nxt = ques_en_r;
      default: begin
        rsp_nxt = 16'h0000;
        rsp_go = 1'b0;
      end
    endcase
  end

  // command execution and answers
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      neg_prot_r <= 16'h0000;
      pos_prot_r <= 16'h0000;
      neg_ceil_r <= 16'h0000;
      pos_ceil_r <= 16'h0000;
      pending_level_r <= 16'h0000;
      prot_mode_r <= `VPS_PM_FIX;
      oper_en_r <= `VPS_EN_RESET;
      ques_en_r <= `VPS_EN_RESET;
      boot_r <= 1'b1;
      cmd_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      second_r <= 16'h0000;
      nv_wr_r <= 1'b0;
      nv_pos_wdata_r <= 16'h0000;
      nv_neg_wdata_r <= 16'h0000;
    end else if (clk_en) begin
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
      nv_wr_r <= 1'b0;
      if (boot_r) begin
        // power-up ceilings come from the persisted copy
        boot_r <= 1'b0;
        pos_ceil_r <= nv_pos_ceil;
        neg_ceil_r <= nv_neg_ceil;
        pos_prot_r <= nv_pos_ceil;
        neg_prot_r <= nv_neg_ceil;
        cmd_ready_r <= 1'b1;
      end else if (!cmd_ready_r) begin
        // second word of a two-word answer
        rsp_valid_r <= 1'b1;
        rsp_data_r <= second_r;
        cmd_ready_r <= 1'b1;
      end else if (take) begin
        if (rsp_go) begin
          rsp_valid_r <= 1'b1;
          rsp_data_r <= rsp_nxt;
          second_r <= second_nxt;
          cmd_ready_r <= ~rsp_two;
        end
        case (cmd_code)
          `VPS_C_PROT_NEG_WR, `VPS_C_PROT_POS_WR, `VPS_C_PROT_BOTH_WR,
          `VPS_C_CEIL_BOTH_WR, `VPS_C_CEIL_NEG_WR, `VPS_C_CEIL_POS_WR: begin
            if (!d_ok) begin
              rsp_valid_r <= 1'b1;
              rsp_err_r <= 1'b1;
              rsp_data_r <= `VPS_ERR_RANGE;
            end else begin
              // a limit written here never passes its own ceiling; a later ceiling write leaves it as it is
              if (cmd_code == `VPS_C_PROT_NEG_WR || cmd_code == `VPS_C_PROT_BOTH_WR) begin
                neg_prot_r <= (d > neg_ceil_r) ? neg_ceil_r : d;
              end
              if (cmd_code == `VPS_C_PROT_POS_WR || cmd_code == `VPS_C_PROT_BOTH_WR) begin
                pos_prot_r <= (d > pos_ceil_r) ? pos_ceil_r : d;
              end
              if (cmd_code == `VPS_C_CEIL_BOTH_WR || cmd_code == `VPS_C_CEIL_NEG_WR) begin
                neg_ceil_r <= d;
              end
              if (cmd_code == `VPS_C_CEIL_BOTH_WR || cmd_code == `VPS_C_CEIL_POS_WR) begin
                pos_ceil_r <= d;
              end
            end
          end
          `VPS_C_TRIG_WR: begin
            if (d > MODEL_MAX) begin
              rsp_valid_r <= 1'b1;
              rsp_err_r <= 1'b1;
              rsp_data_r <= `VPS_ERR_RANGE;
            end else if (d > software_voltage_cap) begin
              pending_level_r <= software_voltage_cap;
            end else begin
              pending_level_r <= d;
            end
          end
          `VPS_C_PERSIST: begin
            // ceilings reach the nonvolatile store only here
            nv_wr_r <= 1'b1;
            nv_pos_wdata_r <= pos_ceil_r;
            nv_neg_wdata_r <= neg_ceil_r;
          end
          `VPS_C_PMODE_WR: begin
            if (d[1:0] != 2'h3) begin
              prot_mode_r <= d[1:0];
            end
          end
          `VPS_C_OPER_EN_WR: oper_en_r <= d & `VPS_OPER_USED;
          `VPS_C_QUES_EN_WR: ques_en_r <= d & `VPS_QUES_USED;
          `VPS_C_PRESET: begin
            oper_en_r <= `VPS_OPER_EN_PRESET;
            ques_en_r <= `VPS_QUES_EN_PRESET;
          end
          default: begin
            oper_en_r <= oper_en_r;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // summaries and effective limits

  reg [`VPS_VW-1:0] pos_nxt;
  reg [`VPS_VW-1:0] neg_nxt;

  // effective limits by source mode
  always @* begin
    case (prot_mode_r)
      `VPS_PM_EXT: begin
        pos_nxt = ext_pos_limit;
        neg_nxt = ext_neg_limit;
      end
      `VPS_PM_LESS: begin
        pos_nxt = (ext_pos_limit < pos_prot_r) ? ext_pos_limit : pos_prot_r;
        neg_nxt = (ext_neg_limit < neg_prot_r) ? ext_neg_limit : neg_prot_r;
      end
      default: begin
        pos_nxt = pos_prot_r;
        neg_nxt = neg_prot_r;
      end
    endcase
  end

  // registered outputs
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      eff_pos_limit_r <= 16'h0000;
      eff_neg_limit_r <= 16'h0000;
      oper_summary_r <= 1'b0;
      ques_summary_r <= 1'b0;
    end else if (clk_en) begin
      eff_pos_limit_r <= pos_nxt;
      eff_neg_limit_r <= neg_nxt;
      oper_summary_r <= |(oper_evt & oper_en_r);
      ques_summary_r <= |(ques_evt & ques_en_r);
    end
  end

endmodule

// *** vps_defines.vh ***
// command codes, status bit layouts, preset values and error codes
`ifndef VPS_DEFINES_VH
`define VPS_DEFINES_VH

// widths
`define VPS_VW 16
`define VPS_CW 5
`define VPS_SW 16

// command codes on cmd_code
`define VPS_C_PROT_NEG_WR 5'h01
`define VPS_C_PROT_NEG_RD 5'h02
`define VPS_C_PROT_POS_WR 5'h03
`define VPS_C_PROT_POS_RD 5'h04
`define VPS_C_PROT_BOTH_WR 5'h05
`define VPS_C_PROT_BOTH_RD 5'h06
`define VPS_C_CEIL_BOTH_WR 5'h07
`define VPS_C_CEIL_BOTH_RD 5'h08
`define VPS_C_CEIL_NEG_WR 5'h09
`define VPS_C_CEIL_NEG_RD 5'h0a
`define VPS_C_CEIL_POS_WR 5'h0b
`define VPS_C_CEIL_POS_RD 5'h0c
`define VPS_C_TRIG_WR 5'h0d
`define VPS_C_TRIG_RD 5'h0e
`define VPS_C_PERSIST 5'h0f
`define VPS_C_PMODE_WR 5'h10
`define VPS_C_PMODE_RD 5'h11
`define VPS_C_OPER_COND_RD 5'h12
`define VPS_C_OPER_EN_WR 5'h13
`define VPS_C_OPER_EN_RD 5'h14
`define VPS_C_OPER_EVT_RD 5'h15
`define VPS_C_PRESET 5'h16
`define VPS_C_QUES_EVT_RD 5'h17
`define VPS_C_QUES_COND_RD 5'h18
`define VPS_C_QUES_EN_WR 5'h19
`define VPS_C_QUES_EN_RD 5'h1a

// protection limit source modes
`define VPS_PM_FIX 2'h0
`define VPS_PM_EXT 2'h1
`define VPS_PM_LESS 2'h2

// status bit layouts: implemented bits and latching bits
`define VPS_OPER_USED 16'h5f60
`define VPS_OPER_LATCH 16'h5f60
`define VPS_QUES_USED 16'h704b
`define VPS_QUES_LATCH 16'h3000

// reset and preset values
`define VPS_EN_RESET 16'h0000
`define VPS_OPER_EN_PRESET 16'h2001
`define VPS_QUES_EN_PRESET 16'h00ff

// error code -222 as 16-bit two's complement
`define VPS_ERR_RANGE 16'hff22

`endif

// *** vps_sync.v ***
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module vps_sync #(
  parameter W = 16
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  // data
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg stab_r;
      // first stage feeds only the second
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          meta_r <= 1'b0;
          stab_r <= 1'b0;
        end else if (clk_en) begin
          meta_r <= async_in[i];
          stab_r <= meta_r;
        end
      end
      assign sync_out[i] = stab_r;
    end
  endgenerate

endmodule

// *** vps_evt.v ***
// event latch: rising edges of chosen condition bits, cleared by read
`timescale 1ns/1ps
module vps_evt #(
  parameter [15:0] LATCH = 16'h0000
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  // condition and read strobe
  input wire [15:0] cond,
  input wire rd_clr,
  output reg [15:0] evt_r
);

  reg [15:0] prev_r;
  wire [15:0] set_now;

  // only latching bits capture a new rising condition
  assign set_now = cond & ~prev_r & LATCH;

  // a set in the clear cycle survives the clear
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 16'h0000;
      evt_r <= 16'h0000;
    end else if (clk_en) begin
      prev_r <= cond;
      if (rd_clr) begin
        evt_r <= set_now;
      end else begin
        evt_r <= evt_r | set_now;
      end
    end
  end

endmodule

// *** vps_regs_properties.sv ***
// checker for the command, answer and persist ports of the register bank
`timescale 1ns/1ps
`include "vps_defines.vh"
module vps_regs_chk #(
  parameter [15:0] RATED_V = 16'h8ca0,
  parameter [15:0] MIN_BOX = 16'h0064,
  parameter [15:0] MODEL_MAX = 16'h8ca0
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire resetn,
  input wire clk_en,
  // command and answer
  input wire cmd_valid,
  input wire [4:0] cmd_code,
  input wire [15:0] cmd_data,
  input wire cmd_ready_r,
  input wire rsp_valid_r,
  input wire rsp_err_r,
  input wire [15:0] rsp_data_r,
  // cap and results
  input wire [15:0] software_voltage_cap,
  input wire nv_wr_r,
  input wire [15:0] pending_level_r
);
  // command accepted at this edge
  wire took = cmd_valid && cmd_ready_r && clk_en;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // one code taken
  sequence s_took(logic [4:0] c);
    took && cmd_code == c;
  endsequence
  // first word with port busy, then second word
  sequence s_two_words;
    rsp_valid_r && !cmd_ready_r ##1 rsp_valid_r && cmd_ready_r;
  endsequence
  property p_err_code;
    rsp_err_r |-> rsp_valid_r && rsp_data_r == `VPS_ERR_RANGE;
  endproperty
  a_err_code: assert property (p_err_code) else $error("error pulse without range code");
  property p_trig_rd;
    s_took(`VPS_C_TRIG_RD) |=> rsp_valid_r && rsp_data_r == pending_level_r;
  endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("pending level answer wrong");
  property p_both_rd;
    s_took(`VPS_C_CEIL_BOTH_RD) |=> s_two_words;
  endproperty
  a_both_rd: assert property (p_both_rd) else $error("ceiling pair answer malformed");
  property p_trig_cap;
    s_took(`VPS_C_TRIG_WR) ##0 (cmd_data <= MODEL_MAX && cmd_data > software_voltage_cap)
      |=> pending_level_r == $past(software_voltage_cap);
  endproperty
  a_trig_cap: assert property (p_trig_cap) else $error("pending level not capped");
  property p_trig_range;
    s_took(`VPS_C_TRIG_WR) ##0 cmd_data > MODEL_MAX |=> rsp_err_r && $stable(pending_level_r);
  endproperty
  a_trig_range: assert property (p_trig_range) else $error("oversize level not refused");
  property p_oper_bits;
    s_took(`VPS_C_OPER_COND_RD) |=> (rsp_data_r & ~16'h5f60) == 16'h0000;
  endproperty
  a_oper_bits: assert property (p_oper_bits) else $error("unused operation bit set");
  property p_neg_range;
    s_took(`VPS_C_PROT_NEG_WR) ##0 cmd_data < MIN_BOX |=> rsp_err_r;
  endproperty
  a_neg_range: assert property (p_neg_range) else $error("low negative limit not refused");
  property p_persist;
    s_took(`VPS_C_PERSIST) |=> nv_wr_r;
  endproperty
  a_persist: assert property (p_persist) else $error("persist strobe missing");
endmodule

bind vps_regs vps_regs_chk #(.RATED_V(RATED_V), .MIN_BOX(MIN_BOX), .MODEL_MAX(MODEL_MAX)) chk (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .clk_en(clk_en),
  .cmd_valid(cmd_valid),
  .cmd_code(cmd_code),
  .cmd_data(cmd_data),
  .cmd_ready_r(cmd_ready_r),
  .rsp_valid_r(rsp_valid_r),
  .rsp_err_r(rsp_err_r),
  .rsp_data_r(rsp_data_r),
  .software_voltage_cap(software_voltage_cap),
  .nv_wr_r(nv_wr_r),
  .pending_level_r(pending_level_r)
);

// *** vps_host.sv ***
// host model: issues one command at a time and collects answer words
`timescale 1ns/1ps
module vps_host (
  // clock
  input wire sys_clk,
  // command request
  output reg cmd_valid,
  output reg [4:0] cmd_code,
  output reg [15:0] cmd_data,
  // handshake and answer
  input wire cmd_ready_r,
  input wire rsp_valid_r,
  input wire rsp_err_r,
  input wire [15:0] rsp_data_r
);
  // idle lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 5'h00;
    cmd_data = 16'h0000;
  end
  // hold request until taken, then sample one or two answer words
  task automatic xfer(input [4:0] c, input [15:0] d, input two, output v, output e,
    output [15:0] w0, output [15:0] w1, output to);
    integer n;
    begin
      n = 0;
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      @(posedge sys_clk);
      while (cmd_ready_r !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      to = (cmd_ready_r !== 1'b1);
      // released lines show the inverse, not the last value
      cmd_valid <= 1'b0;
      cmd_code <= ~c;
      cmd_data <= ~d;
      // first answer word is launched at the taking edge, read once settled
      #1;
      v = rsp_valid_r;
      e = rsp_err_r;
      w0 = rsp_data_r;
      w1 = rsp_data_r;
      if (two) begin
        @(posedge sys_clk);
        #1;
        w1 = rsp_data_r;
      end
    end
  endtask
endmodule

// *** vps_regs_tb.sv ***
// self-checking bench for the protection and status register bank
`timescale 1ns/1ps
`include "vps_defines.vh"
`define VPS_CK(nm, x, y) begin num_checks = num_checks + 1; if ((y) !== (x)) begin error_cnt = error_cnt + 1; \
  $display("ERROR %s expected %h seen %h", nm, x, y); end end
module vps_regs_tb;
  localparam [15:0] RV = 16'h4e20;
  localparam [15:0] MB = 16'h0032;
  localparam [15:0] MM = 16'h4a38;
  localparam [15:0] ML = RV + RV / 16'h0064;
  reg sys_clk, resetn, clk_en, v, e, to, lat;
  reg [7:0] opin;
  reg [6:0] qpin;
  reg [15:0] software_voltage_cap, ext_pos_limit, ext_neg_limit, nv_pos_ceil, nv_neg_ceil, w0, w1;
  wire cmd_valid, cmd_ready_r, rsp_valid_r, rsp_err_r, nv_wr_r, oper_summary_r, ques_summary_r;
  wire [4:0] cmd_code;
  wire [15:0] cmd_data, rsp_data_r, nv_pos_wdata_r, nv_neg_wdata_r, pending_level_r, eff_pos_limit_r, eff_neg_limit_r;
  integer error_cnt, num_checks, i;
  integer obit [0:7];
  integer qbit [0:6];
  // design with small rated values, status pins from two vectors
  vps_regs #(.RATED_V(RV), .MIN_BOX(MB), .MODEL_MAX(MM)) uut (.*, .clk_en(clk_en),
    .list_active_flag(opin[0]), .list_done_flag(opin[1]), .sample_done_flag(opin[2]), .const_current_flag(opin[3]),
    .transient_done_flag(opin[4]), .const_voltage_flag(opin[5]), .transient_primed_flag(opin[6]),
    .awaiting_trigger_flag(opin[7]), .absorbing_energy_flag(qpin[0]), .current_fault_flag(qpin[1]),
    .voltage_fault_flag(qpin[2]), .follower_fault_flag(qpin[3]), .thermal_fault_flag(qpin[4]),
    .current_mode_fault_flag(qpin[5]), .voltage_mode_fault_flag(qpin[6]));
  // host on the command port
  vps_host host (.*);
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // one command, hang cut short
  task cmd(input [4:0] c, input [15:0] d, input two);
    begin
      host.xfer(c, d, two, v, e, w0, w1, to);
      if (to) begin
        error_cnt = error_cnt + 1;
        $display("ERROR handshake expected ready seen timeout");
        conclude;
      end
    end
  endtask
  // query and write helpers
  task qry(input [4:0] c, input [15:0] x);
    begin
      cmd(c, 16'h0000, 1'b0);
      `VPS_CK("answer", {1'b1, x}, {v, w0})
    end
  endtask
  task qry2(input [4:0] c, input [15:0] x0, input [15:0] x1);
    begin
      cmd(c, 16'h0000, 1'b1);
      `VPS_CK("answer pair", {x0, x1}, {w0, w1})
    end
  endtask
  task wr(input [4:0] c, input [15:0] d, input bad);
    begin
      cmd(c, d, 1'b0);
      `VPS_CK("write answer", {bad, bad}, {v, e})
      if (bad) `VPS_CK("error code", 16'hff22, w0)
    end
  endtask
  // ceilings: boot load, range edges, combined write, persist
  task t_ceilings;
    begin
      qry2(`VPS_C_CEIL_BOTH_RD, 16'h3a98, 16'h2ee0);
      wr(`VPS_C_CEIL_POS_WR, ML, 1'b0);
      wr(`VPS_C_CEIL_NEG_WR, 16'h1000, 1'b0);
      qry2(`VPS_C_CEIL_BOTH_RD, ML, 16'h1000);
      wr(`VPS_C_CEIL_POS_WR, ML + 16'h0001, 1'b1);
      wr(`VPS_C_CEIL_NEG_WR, ML + 16'h0001, 1'b1);
      wr(`VPS_C_CEIL_BOTH_WR, 16'h4000, 1'b0);
      qry(`VPS_C_CEIL_POS_RD, 16'h4000);
      qry(`VPS_C_CEIL_NEG_RD, 16'h4000);
      wr(`VPS_C_PERSIST, 16'h0000, 1'b0);
      `VPS_CK("persist", {1'b1, 16'h4000, 16'h4000}, {nv_wr_r, nv_pos_wdata_r, nv_neg_wdata_r})
    end
  endtask
  // limits: range edges, clamp, common write lowers one side
  task t_limits;
    begin
      wr(`VPS_C_PROT_NEG_WR, MB - 16'h0001, 1'b1);
      wr(`VPS_C_PROT_NEG_WR, MB, 1'b0);
      qry(`VPS_C_PROT_NEG_RD, MB);
      wr(`VPS_C_PROT_POS_WR, ML + 16'h0001, 1'b1);
      wr(`VPS_C_PROT_POS_WR, ML, 1'b0);
      qry(`VPS_C_PROT_POS_RD, 16'h4000);
      wr(`VPS_C_CEIL_POS_WR, 16'h0800, 1'b0);
      wr(`VPS_C_PROT_BOTH_WR, 16'h1000, 1'b0);
      qry2(`VPS_C_PROT_BOTH_RD, 16'h0800, 16'h1000);
    end
  endtask
  // source modes lesser, external, fixed
  task t_modes;
    begin
      for (i = 2; i >= 0; i = i - 1) begin
        wr(`VPS_C_PMODE_WR, i[15:0], 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
        `VPS_CK("limits", (i == 2) ? 32'h04001000 : (i == 1) ? 32'h04002000 : 32'h08001000,
          {eff_pos_limit_r, eff_neg_limit_r})
      end
      wr(`VPS_C_PMODE_WR, 16'h0003, 1'b0);
      qry(`VPS_C_PMODE_RD, 16'h0000);
    end
  endtask
  // clock enable low freezes syncs, events and summary
  task t_freeze;
    begin
      @(posedge sys_clk);
      clk_en <= 1'b0;
      opin[3] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1;
      `VPS_CK("frozen summary", 1'b0, oper_summary_r)
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      `VPS_CK("thawed summary", 1'b1, oper_summary_r)
      qry(`VPS_C_OPER_EVT_RD, 16'h0400);
      @(posedge sys_clk);
      opin[3] <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask
  // pending level: refusal, cap, read back
  task t_trigger;
    begin
      wr(`VPS_C_TRIG_WR, MM + 16'h0001, 1'b1);
      `VPS_CK("pending", 16'h0000, pending_level_r)
      wr(`VPS_C_TRIG_WR, MM, 1'b0);
      qry(`VPS_C_TRIG_RD, 16'h3e80);
      wr(`VPS_C_TRIG_WR, 16'h02bc, 1'b0);
      qry(`VPS_C_TRIG_RD, 16'h02bc);
    end
  endtask
  // operation group, one pin at a time
  task t_oper;
    begin
      wr(`VPS_C_OPER_EN_WR, 16'hffff, 1'b0);
      qry(`VPS_C_OPER_EN_RD, 16'h5f60);
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge sys_clk);
        opin[i] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        qry(`VPS_C_OPER_COND_RD, 16'h0001 << obit[i]);
        `VPS_CK("operation summary", 1'b1, oper_summary_r)
        qry(`VPS_C_OPER_EVT_RD, 16'h0001 << obit[i]);
        qry(`VPS_C_OPER_EVT_RD, 16'h0000);
        `VPS_CK("operation summary", 1'b0, oper_summary_r)
        @(posedge sys_clk);
        opin[i] <= 1'b0;
        repeat (6) @(posedge sys_clk);
      end
    end
  endtask
  // questionable group, only two bits latch
  task t_ques;
    begin
      wr(`VPS_C_QUES_EN_WR, 16'hffff, 1'b0);
      qry(`VPS_C_QUES_EN_RD, 16'h704b);
      for (i = 0; i < 7; i = i + 1) begin
        lat = (qbit[i] == 13 || qbit[i] == 12);
        @(posedge sys_clk);
        qpin[i] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        qry(`VPS_C_QUES_COND_RD, 16'h0001 << qbit[i]);
        `VPS_CK("questionable summary", lat, ques_summary_r)
        qry(`VPS_C_QUES_EVT_RD, lat ? 16'h0001 << qbit[i] : 16'h0000);
        qry(`VPS_C_QUES_EVT_RD, 16'h0000);
        @(posedge sys_clk);
        qpin[i] <= 1'b0;
        repeat (6) @(posedge sys_clk);
      end
    end
  endtask
  // preset values of both masks
  task t_preset;
    begin
      wr(`VPS_C_PRESET, 16'h0000, 1'b0);
      qry(`VPS_C_OPER_EN_RD, 16'h2001);
      qry(`VPS_C_QUES_EN_RD, 16'h00ff);
    end
  endtask
  // reset, then the scenarios
  initial begin
    error_cnt = 0;
    num_checks = 0;
    obit = '{14, 12, 11, 10, 9, 8, 6, 5};
    qbit = '{14, 13, 12, 6, 3, 1, 0};
    resetn = 1'b0;
    clk_en = 1'b1;
    opin = 8'h00;
    qpin = 7'h00;
    software_voltage_cap = 16'h3e80;
    ext_pos_limit = 16'h0400;
    ext_neg_limit = 16'h2000;
    nv_pos_ceil = 16'h3a98;
    nv_neg_ceil = 16'h2ee0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_ceilings;
    t_limits;
    t_modes;
    t_trigger;
    t_oper;
    t_freeze;
    t_ques;
    t_preset;
    conclude;
  end
endmodule
